// ==== lmirx_map.vh ====
`ifndef LMIRX_MAP_VH
`define LMIRX_MAP_VH
// APB register byte offsets
`define LMIRX_OFF_INSTR 12'h000
`define LMIRX_OFF_CTRL 12'h004
`define LMIRX_OFF_STATUS 12'h008
`define LMIRX_OFF_WORK 12'h00C
`define LMIRX_OFF_BANK 12'h010
`define LMIRX_OFF_PAGE 12'h014
`define LMIRX_OFF_PTR0 12'h018
`define LMIRX_OFF_PTR1 12'h01C
`define LMIRX_OFF_IRQCTL 12'h020
`define LMIRX_OFF_PWRCTL 12'h024
`define LMIRX_OFF_STACK 12'h028
`define LMIRX_OFF_PC 12'h02C
// field positions
`define LMIRX_GIE_BIT 7
`define LMIRX_RI_BIT 2
`define LMIRX_CTRL_GO_BIT 0
// reset values
`define LMIRX_RST_PWRCTL 8'h04
`define LMIRX_RST_IRQCTL 8'h00
// timing counts, in instruction cycles
`define LMIRX_CYC_RETURN_FROM_IRQ 2
`define LMIRX_CYC_SINGLE 1
// indirect access port addresses in the file
`define LMIRX_ADDR_IND0 7'h00
`define LMIRX_ADDR_IND1 7'h01
`endif

// ==== lmirx_ptr_unit.v ====
`timescale 1ns/1ps
// ============================================================
// indirect pointer address and update unit
module lmirx_ptr_unit #(
    parameter PW = 16
) (
    // pointer and operands
    input wire [PW-1:0] ptr,
    input wire [1:0] mode,
    input wire [5:0] offset,
    input wire relative,
    // results
    output reg [PW-1:0] target,
    output reg [PW-1:0] next_ptr
);
    wire [PW-1:0] plus_one;
    wire [PW-1:0] minus_one;
    wire [PW-1:0] ofs_ext;
    // widths kept at PW so overflow wraps modulo the range
    assign plus_one = ptr + {{(PW-1){1'b0}}, 1'b1};
    assign minus_one = ptr - {{(PW-1){1'b0}}, 1'b1};
    assign ofs_ext = {{(PW-6){offset[5]}}, offset};

    // address and pointer write-back selection
    always @* begin
        target = ptr;
        next_ptr = ptr;
        if (relative) begin
            target = ptr + ofs_ext;
            next_ptr = ptr;
        end else begin
            case (mode)
                2'b00: begin
                    target = plus_one;
                    next_ptr = plus_one;
                end
                2'b01: begin
                    target = minus_one;
                    next_ptr = minus_one;
                end
                2'b10: begin
                    target = ptr;
                    next_ptr = plus_one;
                end
                2'b11: begin
                    target = ptr;
                    next_ptr = minus_one;
                end
                default: begin
                    target = ptr;
                    next_ptr = ptr;
                end
            endcase
        end
    end
endmodule // lmirx_ptr_unit

// ==== lmirx_exec.v ====
// Summary of operation
// - bank literal loads 5 bits into bank select
// - page literal loads 7 bits into latch
// - working literal loads W in one cycle
// - store W to file register f
// - indirect address: ptr, ptr+1, ptr-1 or ptr+k
// - mode 00/01/10/11 pre/pre/post/post inc/dec
// - pointer ends incremented, decremented or unchanged
// - indirect port addresses redirect through pointer
// - pointers are 16 bits and wrap
// - pointer updates touch no status flag
// - software reset resets and clears reset flag
// - return from irq pops stack, two cycles
// - return from irq sets enable bit 7
// - indirect store writes W around pointer update
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "lmirx_map.vh"
module lmirx_exec #(
    parameter PW = 16,
    parameter SD = 16
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // register file write port
    output reg file_we,
    output reg [PW-1:0] file_addr,
    output reg [7:0] file_wdata,
    // stack pop strobe and core reset request
    output reg stack_pop,
    output reg soft_reset_req
);
    // ============================================================
    // opcodes (14-bit instruction word)
    localparam [13:0] OP_NOP = 14'h0000;
    localparam [13:0] OP_RESET = 14'h0001;
    localparam [13:0] OP_RETURN_FROM_IRQ = 14'h0009;

    // ============================================================
    // state machine, one-hot
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_EXEC = 3'b010;
    localparam [2:0] S_RET2 = 3'b100;

    reg [2:0] state;
    reg [13:0] instr;
    reg [7:0] work;
    reg [4:0] bank_select_reg;
    reg [6:0] pc_high_latch;
    reg [PW-1:0] ptr0;
    reg [PW-1:0] ptr1;
    reg [7:0] irq_control_reg;
    reg [7:0] power_control_reg;
    reg [14:0] pc;
    reg [14:0] stack_mem [0:SD-1];
    reg [3:0] sp;
    reg [7:0] executed;
    reg busy;

    // ============================================================
    // instruction class decoding
    function [2:0] lmirx_class;
        input [13:0] w;
        begin
            if (w[13:5] == 9'b000000001)
                lmirx_class = 3'd1; // bank literal
            else if (w[13:7] == 7'b1100011)
                lmirx_class = 3'd2; // page literal
            else if (w[13:8] == 6'b110000)
                lmirx_class = 3'd3; // working literal
            else if (w[13:7] == 7'b0000001)
                lmirx_class = 3'd4; // store to file
            else if (w[13:3] == 11'b00000000011 || w[13:7] == 7'b1111111)
                lmirx_class = 3'd5; // indirect store
            else
                lmirx_class = 3'd0;
        end
    endfunction

    wire [2:0] cls;
    wire relative;
    wire sel1;
    wire [PW-1:0] cur_ptr;
    wire [PW-1:0] ind_target;
    wire [PW-1:0] ind_next;
    wire [PW-1:0] direct_addr;
    assign cls = lmirx_class(instr);
    assign relative = (instr[13:7] == 7'b1111111);
    assign sel1 = relative ? instr[6] : instr[2];
    assign cur_ptr = sel1 ? ptr1 : ptr0;
    assign direct_addr = {{(PW-12){1'b0}}, bank_select_reg, instr[6:0]};

    lmirx_ptr_unit #(.PW(PW)) u_ptr (
        .ptr(cur_ptr),
        .mode(instr[1:0]),
        .offset(instr[5:0]),
        .relative(relative),
        .target(ind_target),
        .next_ptr(ind_next)
    );

    // ============================================================
    // apb access decode
    wire wr_acc;
    wire rd_acc;
    wire [11:0] off;
    assign wr_acc = psel & penable & pwrite & pready;
    assign rd_acc = psel & ~penable & ~pwrite;
    assign off = {paddr[11:2], 2'b00};

    // zero-wait-state answer: pready rises in the access phase
    always @(posedge clk) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr[1:0] != 2'b00 || paddr > `LMIRX_OFF_PC);
        end
    end

    // read data mux, registered at setup so it is valid in the access phase
    always @(posedge clk) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (rd_acc) begin
            case (off)
                `LMIRX_OFF_INSTR: prdata <= {18'h00000, instr};
                `LMIRX_OFF_STATUS: prdata <= {23'h000000, busy, executed};
                `LMIRX_OFF_WORK: prdata <= {24'h000000, work};
                `LMIRX_OFF_BANK: prdata <= {27'h0000000, bank_select_reg};
                `LMIRX_OFF_PAGE: prdata <= {25'h0000000, pc_high_latch};
                `LMIRX_OFF_PTR0: prdata <= {{(32-PW){1'b0}}, ptr0};
                `LMIRX_OFF_PTR1: prdata <= {{(32-PW){1'b0}}, ptr1};
                `LMIRX_OFF_IRQCTL: prdata <= {24'h000000, irq_control_reg};
                `LMIRX_OFF_PWRCTL: prdata <= {24'h000000, power_control_reg};
                `LMIRX_OFF_STACK: prdata <= {17'h00000, stack_mem[sp]};
                `LMIRX_OFF_PC: prdata <= {17'h00000, pc};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ============================================================
    // execution engine; a write to control bit 0 launches the held instruction
    // software may not alter core registers over the bus while busy
    always @(posedge clk) begin
        if (!resetn) begin
            state <= S_IDLE;
            instr <= 14'h0000;
            work <= 8'h00;
            bank_select_reg <= 5'h00;
            pc_high_latch <= 7'h00;
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
            irq_control_reg <= `LMIRX_RST_IRQCTL;
            pc <= 15'h0000;
            sp <= 4'h0;
            executed <= 8'h00;
            busy <= 1'b0;
            file_we <= 1'b0;
            file_addr <= 16'h0000;
            file_wdata <= 8'h00;
            stack_pop <= 1'b0;
            soft_reset_req <= 1'b0;
        end else begin
            file_we <= 1'b0;
            stack_pop <= 1'b0;
            soft_reset_req <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (wr_acc) begin
                        case (off)
                            `LMIRX_OFF_INSTR: instr <= pwdata[13:0];
                            `LMIRX_OFF_WORK: work <= pwdata[7:0];
                            `LMIRX_OFF_PTR0: ptr0 <= pwdata[PW-1:0];
                            `LMIRX_OFF_PTR1: ptr1 <= pwdata[PW-1:0];
                            `LMIRX_OFF_IRQCTL: irq_control_reg <= pwdata[7:0];
                            `LMIRX_OFF_STACK: begin
                                stack_mem[sp + 4'h1] <= pwdata[14:0];
                                sp <= sp + 4'h1;
                            end
                            `LMIRX_OFF_CTRL: begin
                                if (pwdata[`LMIRX_CTRL_GO_BIT]) begin
                                    state <= S_EXEC;
                                    busy <= 1'b1;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                S_EXEC: begin
                    state <= S_IDLE;
                    busy <= 1'b0;
                    pc <= pc + 15'h0001;
                    executed <= executed + 8'h01;
                    if (instr == OP_RETURN_FROM_IRQ) begin
                        // second cycle spent loading pc from the popped top
                        state <= S_RET2;
                        busy <= 1'b1;
                        stack_pop <= 1'b1;
                        irq_control_reg[`LMIRX_GIE_BIT] <= 1'b1;
                    end else if (instr == OP_RESET) begin
                        // pulses the device reset; this core clears itself too
                        soft_reset_req <= 1'b1;
                        state <= S_IDLE;
                        pc <= 15'h0000;
                        work <= 8'h00;
                        bank_select_reg <= 5'h00;
                        pc_high_latch <= 7'h00;
                        ptr0 <= 16'h0000;
                        ptr1 <= 16'h0000;
                        irq_control_reg <= `LMIRX_RST_IRQCTL;
                    end else begin
                        case (cls)
                            3'd1: bank_select_reg <= instr[4:0];
                            3'd2: pc_high_latch <= instr[6:0];
                            3'd3: work <= instr[7:0];
                            3'd4: begin
                                // indirect port names carry no storage
                                file_we <= 1'b1;
                                file_wdata <= work;
                                if (instr[6:0] == `LMIRX_ADDR_IND0)
                                    file_addr <= ptr0;
                                else if (instr[6:0] == `LMIRX_ADDR_IND1)
                                    file_addr <= ptr1;
                                else
                                    file_addr <= direct_addr;
                            end
                            3'd5: begin
                                // w is left alone, no flag path exists here
                                file_we <= 1'b1;
                                file_wdata <= work;
                                file_addr <= ind_target;
                                if (sel1)
                                    ptr1 <= ind_next;
                                else
                                    ptr0 <= ind_next;
                            end
                            default: ; // no-op changes nothing else
                        endcase
                    end
                end
                S_RET2: begin
                    pc <= stack_mem[sp];
                    sp <= sp - 4'h1;
                    state <= S_IDLE;
                    busy <= 1'b0;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ============================================================
    // power control: the flag survives the reset it reports
    always @(posedge clk) begin
        if (!resetn) begin
            power_control_reg <= `LMIRX_RST_PWRCTL;
        end else if (state == S_EXEC && instr == OP_RESET) begin
            power_control_reg[`LMIRX_RI_BIT] <= 1'b0;
        end else if (wr_acc && off == `LMIRX_OFF_PWRCTL && state == S_IDLE) begin
            power_control_reg <= pwdata[7:0];
        end
    end
endmodule // lmirx_exec

// ==== lmirx_exec_monitor.sv ====
`timescale 1ns/1ps
// ==========
// port checker for the executor
module lmirx_exec_monitor (
    // clock and reset
    input logic clk,
    input logic resetn,
    // apb
    input logic psel,
    input logic penable,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // core side strobes
    input logic file_we,
    input logic stack_pop,
    input logic soft_reset_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // setup cycle seen by the slave
    wire setup = psel && !penable;
    property p_ready; setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready late");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready held");
    property p_err_align; setup && paddr[1:0] != 2'h0 |=> pslverr; endproperty
    a_err_align: assert property (p_err_align) else $error("misaligned not refused");
    property p_err_range; setup && paddr > 12'h02C |=> pslverr && pready; endproperty
    a_err_range: assert property (p_err_range) else $error("range not refused");
    property p_no_err; setup && paddr[1:0] == 2'h0 && paddr <= 12'h02C |=> !pslverr; endproperty
    a_no_err: assert property (p_no_err) else $error("spurious pslverr");
    property p_pop_once; stack_pop |=> !stack_pop ##1 !stack_pop; endproperty
    a_pop_once: assert property (p_pop_once) else $error("double pop");
    property p_pop_alone; stack_pop |-> !file_we && !soft_reset_req; endproperty
    a_pop_alone: assert property (p_pop_alone) else $error("pop with write");
    property p_sreset_once; soft_reset_req |=> !soft_reset_req; endproperty
    a_sreset_once: assert property (p_sreset_once) else $error("reset request held");
    property p_we_once; file_we |=> !file_we; endproperty
    a_we_once: assert property (p_we_once) else $error("write strobe held");
    // outputs must come out of reset quiet, not with stale values
    property p_quiet; $rose(resetn) |-> !pready && !file_we && !stack_pop && prdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs live after reset");
    c_write: cover property (file_we);
    c_pop: cover property (stack_pop);
    c_sreset: cover property (soft_reset_req);
endmodule // lmirx_exec_monitor

bind lmirx_exec lmirx_exec_monitor i_mon (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .file_we(file_we),
    .stack_pop(stack_pop), .soft_reset_req(soft_reset_req));

// ==== lmirx_file_model.sv ====
`timescale 1ns/1ps
// ==========
// data file model: stores writes, counts pops
module lmirx_file_model (
    // clock
    input logic clk,
    // write port and stack strobe
    input logic file_we,
    input logic [15:0] file_addr,
    input logic [7:0] file_wdata,
    input logic stack_pop,
    // last write and event counts
    output logic [15:0] last_addr,
    output logic [7:0] last_data,
    output integer writes,
    output integer pops
);
    logic [7:0] mem [0:65535];
    initial writes = 0;
    initial pops = 0;
    // full 64k space, so a wrapped pointer still lands somewhere real
    always @(posedge clk) begin
        if (file_we === 1'b1) begin
            mem[file_addr] <= file_wdata;
            last_addr <= file_addr;
            last_data <= file_wdata;
            writes <= writes + 1;
        end
        if (stack_pop === 1'b1) pops <= pops + 1;
    end
endmodule // lmirx_file_model

// ==== lmirx_exec_tb_top.sv ====
`timescale 1ns/1ps
`include "lmirx_map.vh"
module lmirx_exec_tb_top;
    // ==========
    // signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, file_we, stack_pop, soft_reset_req, e, n;
    logic [15:0] file_addr, m_addr, p, q;
    logic [7:0] file_wdata, m_data, w;
    logic [6:0] f;
    logic [1:0] mm;
    logic [11:0] pa;
    integer bad_count = 0, n_compared = 0, seed = 32'hA8FE4DBB, m_writes, m_pops, i, k, c;
    always #20 clk = ~clk;
    lmirx_exec i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata), .stack_pop(stack_pop),
        .soft_reset_req(soft_reset_req));
    lmirx_file_model i_mem (.clk(clk), .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
        .stack_pop(stack_pop), .last_addr(m_addr), .last_data(m_data), .writes(m_writes), .pops(m_pops));
    // ==========
    // tasks and expectations
    task final_report;
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, g, x);
        end
    endtask
    task fail(input integer t);
        if (t > 20) begin
            bad_count++;
            $display("ERROR %0t: wait ran out", $time);
            final_report;
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer t;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
            fail(t);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    // launch one opcode and poll busy; the return op keeps busy an extra cycle
    task ex(input logic [13:0] op);
        integer t;
        apb(1'b1, `LMIRX_OFF_INSTR, {18'h0, op});
        apb(1'b1, `LMIRX_OFF_CTRL, 32'h1);
        t = 0;
        do begin
            apb(1'b0, `LMIRX_OFF_STATUS, 32'h0);
            t++;
            fail(t);
        end while (r[8] !== 1'b0);
    endtask
    function logic [15:0] tgt(input logic [15:0] v, input logic [1:0] m);
        tgt = (m == 2'h0) ? v + 16'h1 : (m == 2'h1) ? v - 16'h1 : v;
    endfunction
    function logic [15:0] nxt(input logic [15:0] v, input logic [1:0] m);
        nxt = m[0] ? v - 16'h1 : v + 16'h1;
    endfunction
    // ==========
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(`LMIRX_OFF_PWRCTL, 32'h4);
        rd(`LMIRX_OFF_IRQCTL, 32'h0);
        apb(1'b1, 12'h030, 32'h5);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h006, 32'h0);
        chk({31'h0, e}, 32'h1);
        // first two passes pin the all-ones and all-zeros operands, except that f is held at 2 in the zero pass
        for (i = 0; i < 8; i++) begin
            k = (i == 0) ? -1 : (i == 1) ? 0 : $random(seed);
            w = k[7:0];
            f = (k[26:20] < 7'd2) ? 7'd2 : k[26:20];
            ex(14'h3000 | w);
            rd(`LMIRX_OFF_WORK, {24'h0, w});
            ex(14'h0020 | k[12:8]);
            rd(`LMIRX_OFF_BANK, {27'h0, k[12:8]});
            ex(14'h3180 | k[19:13]);
            rd(`LMIRX_OFF_PAGE, {25'h0, k[19:13]});
            ex(14'h0080 | f);
            chk({16'h0, m_addr}, {20'h0, k[12:8], f});
            chk({24'h0, m_data}, {24'h0, w});
            rd(`LMIRX_OFF_WORK, {24'h0, w});
        end
        // every mode on both pointers, wrapping at each end
        for (i = 0; i < 16; i++) begin
            k = $random(seed);
            mm = i[1:0];
            n = i[2];
            p = i[3] ? k[15:0] : (mm[0] ? 16'h0000 : 16'hFFFF);
            q = nxt(p, mm);
            w = k[23:16];
            pa = n ? `LMIRX_OFF_PTR1 : `LMIRX_OFF_PTR0;
            ex(14'h3000 | w);
            apb(1'b1, pa, {16'h0, p});
            ex(14'h0018 | {n, mm});
            chk({16'h0, m_addr}, {16'h0, tgt(p, mm)});
            chk({24'h0, m_data}, {24'h0, w});
            rd(pa, {16'h0, q});
            rd(`LMIRX_OFF_WORK, {24'h0, w});
            ex(14'h0080 | n);
            chk({16'h0, m_addr}, {16'h0, q});
            ex(14'h3F80 | {n, k[29:24]});
            chk({16'h0, m_addr}, {16'h0, q + {{10{k[29]}}, k[29:24]}});
            rd(pa, {16'h0, q});
        end
        c = m_writes;
        ex(14'h0000);
        chk(m_writes, c);
        rd(`LMIRX_OFF_WORK, {24'h0, w});
        apb(1'b1, `LMIRX_OFF_STACK, 32'h5A3);
        ex(14'h0009);
        rd(`LMIRX_OFF_PC, 32'h5A3);
        rd(`LMIRX_OFF_IRQCTL, 32'h80);
        chk(m_pops, 32'h1);
        ex(14'h0001);
        rd(`LMIRX_OFF_PWRCTL, 32'h0);
        rd(`LMIRX_OFF_WORK, 32'h0);
        final_report;
    end
endmodule // lmirx_exec_tb_top
